//--- include/asf_regs.svh
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH

// Task-file register indices; the byte address is four times the index.
`define ASF_IDX_FEATURE      4'h1
`define ASF_IDX_SECCNT       4'h2
`define ASF_IDX_SECNUM       4'h3
`define ASF_IDX_CYL_LOW      4'h4
`define ASF_IDX_CYL_HIGH     4'h5
`define ASF_IDX_DRVHEAD      4'h6
`define ASF_IDX_COMMAND      4'h7

// Block-local registers, byte addresses.
`define ASF_ADDR_STATUS      8'h20
`define ASF_ADDR_MODE        8'h24
`define ASF_ADDR_CTRL        8'h28

// Status register bit positions.
`define ASF_ST_BUSY          0
`define ASF_ST_ABORT         1
`define ASF_ST_SMART_EN      2
`define ASF_ST_AUTOSAVE      3
`define ASF_ST_BYTE_MODE     4
`define ASF_ST_LOOKAHEAD     5
`define ASF_ST_WCACHE        6
`define ASF_ST_POR_RELOAD    7
`define ASF_ST_FLUSHING      8
`define ASF_ST_FATAL         9

// Control register bit positions.
`define ASF_CTRL_SRST        0

// Opcodes.
`define ASF_OP_SET_FEATURES  8'hef
`define ASF_OP_SMART         8'hb0

// Feature codes.
`define ASF_FT_BYTE_ON       8'h01
`define ASF_FT_WCACHE_ON     8'h02
`define ASF_FT_XFER_MODE     8'h03
`define ASF_FT_RLA_OFF       8'h55
`define ASF_FT_POR_OFF       8'h66
`define ASF_FT_NOP_69        8'h69
`define ASF_FT_BYTE_OFF      8'h81
`define ASF_FT_WCACHE_OFF    8'h82
`define ASF_FT_NOP_96        8'h96
`define ASF_FT_NOP_97        8'h97
`define ASF_FT_NOP_9A        8'h9a
`define ASF_FT_RLA_ON        8'haa
`define ASF_FT_LONG4         8'hbb
`define ASF_FT_POR_ON        8'hcc

// Monitoring subcommands and signature.
`define ASF_SM_STATUS        8'hda
`define ASF_SM_AUTOSAVE      8'hd2
`define ASF_SM_ENABLE        8'hd8
`define ASF_SM_DISABLE       8'hd9
`define ASF_SIG_HIGH         8'hc2
`define ASF_SIG_LOW          8'h4f
`define ASF_SIG_BAD_HIGH     8'h2c
`define ASF_SIG_BAD_LOW      8'hf4
`define ASF_AUTOSAVE_OFF     8'h00
`define ASF_AUTOSAVE_ON      8'hf1

// Transfer-mode field values.
`define ASF_XT_PIO_DEF       5'b00000
`define ASF_XT_PIO_FC        5'b00001
`define ASF_XT_MWDMA         5'b00100
`define ASF_XT_UDMA          5'b01000
`define ASF_XM_IORDY_ON      3'b000
`define ASF_XM_IORDY_OFF     3'b001
`define ASF_MAX_PIO          3'd4
`define ASF_MAX_MWDMA        3'd2
`define ASF_MAX_UDMA         3'd4

// Reset values, and the long-sector byte count that feature BBH sets.
`define ASF_PIO_DEF_MODE     3'd0
`define ASF_LONG_BYTES_DEF   8'h04
`define ASF_LONG_BYTES_SET   8'h04

`endif

//--- include/asf_pkg.sv
package asf_pkg;

	typedef enum logic [1:0] {
		ASF_IDLE  = 2'b00,
		ASF_EXEC  = 2'b01,
		ASF_FLUSH = 2'b10
	} asf_state_e;

	typedef enum logic [1:0] {
		ASF_DMA_NONE  = 2'b00,
		ASF_DMA_MW    = 2'b01,
		ASF_DMA_ULTRA = 2'b10
	} asf_dma_e;

endpackage : asf_pkg

//--- src/asf_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser; only the second stage is visible.
module asf_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         cen,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			q      <= '0;
		end else if (cen) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : asf_sync

`default_nettype wire

//--- src/asf_mode_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "asf_regs.svh"

// Decodes the transfer-mode argument of the mode-select feature.
module asf_mode_dec
	import asf_pkg::*;
(
	input  wire logic [7:0] arg,
	output logic            valid,
	output logic            pio_sel,
	output logic            iordy_off,
	output logic [2:0]      mode,
	output asf_dma_e        dma
);

	function automatic logic in_range(input logic [2:0] m, input logic [2:0] max);
		in_range = (m <= max);
	endfunction : in_range

	always_comb begin
		valid     = 1'b0;
		pio_sel   = 1'b0;
		iordy_off = 1'b0;
		mode      = arg[2:0];
		dma       = ASF_DMA_NONE;
		unique case (arg[7:3])
			`ASF_XT_PIO_DEF: begin
				pio_sel   = 1'b1;
				mode      = `ASF_PIO_DEF_MODE;
				iordy_off = (arg[2:0] == `ASF_XM_IORDY_OFF);
				valid     = (arg[2:0] == `ASF_XM_IORDY_ON) || iordy_off;
			end
			`ASF_XT_PIO_FC: begin
				pio_sel = 1'b1;
				valid   = in_range(arg[2:0], `ASF_MAX_PIO);
			end
			`ASF_XT_MWDMA: begin
				dma   = ASF_DMA_MW;
				valid = in_range(arg[2:0], `ASF_MAX_MWDMA);
			end
			`ASF_XT_UDMA: begin
				dma   = ASF_DMA_ULTRA;
				valid = in_range(arg[2:0], `ASF_MAX_UDMA);
			end
			default: valid = 1'b0;
		endcase
	end

endmodule : asf_mode_dec

`default_nettype wire

//--- src/asf_decoder.sv
// Operation
// - Opcode EFH applies the feature in feature_select using sector_count_arg.
// - Feature 01H forces low-byte transfers and withholds the 16-bit select.
// - Feature 81H restores full 16-bit data register transfers.
// - Feature 03H takes type from count bits 7..3, mode from bits 2..0.
// - Types 00001b PIO, 00100b multiword DMA, 01000b Ultra DMA; others reserved.
// - Type 00000b is default PIO; mode 000b keeps IORDY, 001b disables it.
// - One PIO mode always selected, changed only by the feature command.
// - Mode numbers beyond the supported ones are invalid.
// - Feature 55H turns look-ahead off, AAH on; off is the default.
// - 66H stops default reload at software reset, CCH re-enables it.
// - Codes 69H, 96H, 9AH, 97H complete with no effect.
// - Feature BBH sets long-sector extra bytes to four.
// - 02H/82H enable/disable write cache; disabling flushes before completion.
// - Monitoring opcode B0H needs C2H/4FH in cylinder high/low; feature is subcommand.
// - Return status without fatal error loads 4FH mid, C2H high.
// - Return status after fatal error loads F4H mid, 2CH high.
// - Autosave subcommand D2H: count 00H disables, F1H enables, nothing else.
// - D8H enables monitoring access; data is gathered regardless.
// - Repeated enable leaves monitoring state untouched.
// - Monitoring enable state is kept in non-volatile storage.
// - After D9H data keeps being collected for later re-enable.
// - While disabled every monitoring subcommand but enable is aborted.
// - Defaults return at hardware reset, and software reset unless reload disabled.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "asf_regs.svh"

module asf_decoder
	import asf_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        cen,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        fatal_error_pin,
	input  wire logic        flush_done_pin,
	input  wire logic        nv_smart_pin,
	output logic             nv_smart_wr,
	output logic             nv_smart_data,
	output logic             cache_flush_req,
	output logic             iocs16_enable,
	output logic             byte_lanes_low,
	output logic [2:0]       pio_mode,
	output logic             iordy_enable,
	output logic [1:0]       dma_type,
	output logic [2:0]       dma_mode,
	output logic             read_lookahead,
	output logic             write_cache,
	output logic [7:0]       long_extra_bytes,
	output logic             cmd_done,
	output logic             cmd_abort
);

	function automatic logic [7:0] idx_addr(input logic [3:0] idx);
		idx_addr = {2'b00, idx, 2'b00};
	endfunction : idx_addr

	asf_state_e  state_q;
	logic [7:0]  feature_q, seccnt_q, secnum_q, cyl_low_q, cyl_high_q, drvhead_q, opcode_q;
	logic        abort_q;
	logic        smart_en_q, nv_loaded_q, autosave_q;
	logic [1:0]  nv_wait_q;
	logic        por_reload_q;
	logic        fatal_q;
	logic        fatal_s, flush_done_s, nv_smart_s;
	logic        acc, wr_acc, busy, srst, revert;
	logic        sf_cmd, sm_cmd, do_abort, sig_ok, finish;
	logic        md_valid, md_pio, md_iordy_off;
	logic [2:0]  md_mode;
	asf_dma_e    md_dma;
	logic [31:0] rd_d;
	logic        rd_err;

	asf_sync #(.W(3)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.cen     (cen),
		.d       ({fatal_error_pin, flush_done_pin, nv_smart_pin}),
		.q       ({fatal_s, flush_done_s, nv_smart_s})
	);

	asf_mode_dec u_mode_dec (
		.arg       (seccnt_q),
		.valid     (md_valid),
		.pio_sel   (md_pio),
		.iordy_off (md_iordy_off),
		.mode      (md_mode),
		.dma       (md_dma)
	);

	// A write takes effect at the edge where pready is sampled high.
	assign acc    = psel && penable && pready;
	assign wr_acc = acc && pwrite;
	assign busy   = (state_q != ASF_IDLE);
	assign srst   = wr_acc && (paddr == `ASF_ADDR_CTRL) && pwdata[`ASF_CTRL_SRST];
	assign revert = srst && por_reload_q;
	assign sf_cmd = (state_q == ASF_EXEC) && (opcode_q == `ASF_OP_SET_FEATURES);
	assign sm_cmd = (state_q == ASF_EXEC) && (opcode_q == `ASF_OP_SMART);
	assign sig_ok = (cyl_high_q == `ASF_SIG_HIGH) && (cyl_low_q == `ASF_SIG_LOW);

	// Decides whether the command in execution must be aborted.
	always_comb begin
		do_abort = 1'b0;
		if (state_q == ASF_EXEC) begin
			if (sf_cmd) begin
				unique case (feature_q)
					`ASF_FT_BYTE_ON, `ASF_FT_BYTE_OFF, `ASF_FT_WCACHE_ON,
					`ASF_FT_WCACHE_OFF, `ASF_FT_RLA_OFF, `ASF_FT_RLA_ON,
					`ASF_FT_POR_OFF, `ASF_FT_POR_ON, `ASF_FT_LONG4,
					`ASF_FT_NOP_69, `ASF_FT_NOP_96, `ASF_FT_NOP_97,
					`ASF_FT_NOP_9A:  do_abort = 1'b0;
					`ASF_FT_XFER_MODE: do_abort = !md_valid;
					default:         do_abort = 1'b1;
				endcase
			end else if (sm_cmd) begin
				if (!sig_ok) begin
					do_abort = 1'b1;
				end else if (!smart_en_q) begin
					do_abort = (feature_q != `ASF_SM_ENABLE);
				end else begin
					unique case (feature_q)
						`ASF_SM_STATUS, `ASF_SM_ENABLE,
						`ASF_SM_DISABLE: do_abort = 1'b0;
						`ASF_SM_AUTOSAVE: do_abort = (seccnt_q != `ASF_AUTOSAVE_OFF) &&
						                             (seccnt_q != `ASF_AUTOSAVE_ON);
						default:         do_abort = 1'b1;
					endcase
				end
			end else begin
				do_abort = 1'b1;
			end
		end
	end

	// Applying the feature command only on a non-aborted execution cycle.
	logic ok_sf, ok_sm;
	assign ok_sf = sf_cmd && !do_abort;
	assign ok_sm = sm_cmd && !do_abort;

	// Completion: one cycle of execution, or the end of the flush.
	assign finish = ((state_q == ASF_EXEC) &&
	                 !(ok_sf && (feature_q == `ASF_FT_WCACHE_OFF) && write_cache)) ||
	                ((state_q == ASF_FLUSH) && flush_done_s);

	// Command sequencer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ASF_IDLE;
		end else if (cen) begin
			if (srst) begin
				state_q <= ASF_IDLE;
			end else begin
				unique case (state_q)
					ASF_IDLE: begin
						if (wr_acc && (paddr == idx_addr(`ASF_IDX_COMMAND))) begin
							state_q <= ASF_EXEC;
						end
					end
					ASF_EXEC: begin
						state_q <= finish ? ASF_IDLE : ASF_FLUSH;
					end
					ASF_FLUSH: begin
						if (flush_done_s) begin
							state_q <= ASF_IDLE;
						end
					end
					default: state_q <= ASF_IDLE;
				endcase
			end
		end
	end

	// Cache flush request stands until the storage side reports done.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cache_flush_req <= 1'b0;
		end else if (cen) begin
			if (srst || flush_done_s) begin
				cache_flush_req <= 1'b0;
			end else if (state_q == ASF_EXEC && !finish) begin
				cache_flush_req <= 1'b1;
			end
		end
	end

	// Task file written by the host; writes while busy are ignored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feature_q  <= 8'h00;
			seccnt_q   <= 8'h00;
			secnum_q   <= 8'h00;
			drvhead_q  <= 8'h00;
			opcode_q   <= 8'h00;
		end else if (cen && wr_acc && !busy) begin
			unique case (paddr)
				idx_addr(`ASF_IDX_FEATURE): feature_q <= pwdata[7:0];
				idx_addr(`ASF_IDX_SECCNT):  seccnt_q  <= pwdata[7:0];
				idx_addr(`ASF_IDX_SECNUM):  secnum_q  <= pwdata[7:0];
				idx_addr(`ASF_IDX_DRVHEAD): drvhead_q <= pwdata[7:0];
				idx_addr(`ASF_IDX_COMMAND): opcode_q  <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Cylinder registers double as the return-status answer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyl_low_q  <= 8'h00;
			cyl_high_q <= 8'h00;
		end else if (cen) begin
			if (ok_sm && feature_q == `ASF_SM_STATUS) begin
				cyl_low_q  <= fatal_q ? `ASF_SIG_BAD_LOW : `ASF_SIG_LOW;
				cyl_high_q <= fatal_q ? `ASF_SIG_BAD_HIGH : `ASF_SIG_HIGH;
			end else if (wr_acc && !busy) begin
				if (paddr == idx_addr(`ASF_IDX_CYL_LOW)) begin
					cyl_low_q <= pwdata[7:0];
				end
				if (paddr == idx_addr(`ASF_IDX_CYL_HIGH)) begin
					cyl_high_q <= pwdata[7:0];
				end
			end
		end
	end

	// Fatal error is the only threshold; it is latched and kept while disabled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fatal_q <= 1'b0;
		end else if (cen && fatal_s) begin
			fatal_q <= 1'b1;
		end
	end

	// Byte-wide data mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_lanes_low <= 1'b0;
			iocs16_enable  <= 1'b1;
		end else if (cen) begin
			if (revert) begin
				byte_lanes_low <= 1'b0;
				iocs16_enable  <= 1'b1;
			end else if (ok_sf && feature_q == `ASF_FT_BYTE_ON) begin
				byte_lanes_low <= 1'b1;
				iocs16_enable  <= 1'b0;
			end else if (ok_sf && feature_q == `ASF_FT_BYTE_OFF) begin
				byte_lanes_low <= 1'b0;
				iocs16_enable  <= 1'b1;
			end
		end
	end

	// Transfer modes; a PIO mode is held at all times.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pio_mode     <= `ASF_PIO_DEF_MODE;
			iordy_enable <= 1'b1;
			dma_type     <= ASF_DMA_NONE;
			dma_mode     <= 3'd0;
		end else if (cen) begin
			if (revert) begin
				pio_mode     <= `ASF_PIO_DEF_MODE;
				iordy_enable <= 1'b1;
				dma_type     <= ASF_DMA_NONE;
				dma_mode     <= 3'd0;
			end else if (ok_sf && feature_q == `ASF_FT_XFER_MODE) begin
				if (md_pio) begin
					pio_mode     <= md_mode;
					iordy_enable <= !md_iordy_off;
				end else begin
					dma_type <= md_dma;
					dma_mode <= md_mode;
				end
			end
		end
	end

	// Look-ahead, cache, long-sector bytes and default reload control.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_lookahead   <= 1'b0;
			write_cache      <= 1'b0;
			long_extra_bytes <= `ASF_LONG_BYTES_DEF;
		end else if (cen) begin
			if (revert) begin
				read_lookahead   <= 1'b0;
				write_cache      <= 1'b0;
				long_extra_bytes <= `ASF_LONG_BYTES_DEF;
			end else if (ok_sf) begin
				if (feature_q == `ASF_FT_RLA_OFF) read_lookahead <= 1'b0;
				if (feature_q == `ASF_FT_RLA_ON) read_lookahead <= 1'b1;
				if (feature_q == `ASF_FT_WCACHE_ON) write_cache <= 1'b1;
				if (feature_q == `ASF_FT_WCACHE_OFF) write_cache <= 1'b0;
				if (feature_q == `ASF_FT_LONG4) begin
					long_extra_bytes <= `ASF_LONG_BYTES_SET;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_reload_q <= 1'b1;
		end else if (cen && ok_sf) begin
			if (feature_q == `ASF_FT_POR_OFF) por_reload_q <= 1'b0;
			if (feature_q == `ASF_FT_POR_ON) por_reload_q <= 1'b1;
		end
	end

	// Monitoring enable lives in non-volatile storage; it is read back once
	// after reset and every change is written out. The read waits until the
	// synchroniser holds the pin value rather than its own reset value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nv_loaded_q   <= 1'b0;
			nv_wait_q     <= 2'd0;
			smart_en_q    <= 1'b0;
			nv_smart_wr   <= 1'b0;
			nv_smart_data <= 1'b0;
		end else if (cen) begin
			nv_smart_wr <= 1'b0;
			if (!nv_loaded_q) begin
				if (nv_wait_q == 2'd2) begin
					nv_loaded_q <= 1'b1;
					smart_en_q  <= nv_smart_s;
				end else begin
					nv_wait_q <= nv_wait_q + 2'd1;
				end
			end else if (ok_sm && feature_q == `ASF_SM_ENABLE && !smart_en_q) begin
				smart_en_q    <= 1'b1;
				nv_smart_wr   <= 1'b1;
				nv_smart_data <= 1'b1;
			end else if (ok_sm && feature_q == `ASF_SM_DISABLE) begin
				smart_en_q    <= 1'b0;
				nv_smart_wr   <= 1'b1;
				nv_smart_data <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			autosave_q <= 1'b0;
		end else if (cen && ok_sm && feature_q == `ASF_SM_AUTOSAVE) begin
			autosave_q <= (seccnt_q == `ASF_AUTOSAVE_ON);
		end
	end

	// Completion pulses and the sticky abort flag of the last command.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_done  <= 1'b0;
			cmd_abort <= 1'b0;
			abort_q   <= 1'b0;
		end else if (cen) begin
			cmd_done  <= busy && finish && !srst;
			cmd_abort <= (state_q == ASF_EXEC) && do_abort && !srst;
			if (state_q == ASF_EXEC) begin
				abort_q <= do_abort;
			end
		end
	end

	// Read mux; unmapped addresses answer with pslverr.
	always_comb begin
		rd_d   = 32'h0000_0000;
		rd_err = 1'b0;
		unique case (paddr)
			idx_addr(`ASF_IDX_FEATURE),
			idx_addr(`ASF_IDX_COMMAND):  rd_d = 32'h0000_0000;
			idx_addr(`ASF_IDX_SECCNT):   rd_d[7:0] = seccnt_q;
			idx_addr(`ASF_IDX_SECNUM):   rd_d[7:0] = secnum_q;
			idx_addr(`ASF_IDX_CYL_LOW):  rd_d[7:0] = cyl_low_q;
			idx_addr(`ASF_IDX_CYL_HIGH): rd_d[7:0] = cyl_high_q;
			idx_addr(`ASF_IDX_DRVHEAD):  rd_d[7:0] = drvhead_q;
			`ASF_ADDR_STATUS: begin
				rd_d[`ASF_ST_BUSY]       = busy;
				rd_d[`ASF_ST_ABORT]      = abort_q;
				rd_d[`ASF_ST_SMART_EN]   = smart_en_q;
				rd_d[`ASF_ST_AUTOSAVE]   = autosave_q;
				rd_d[`ASF_ST_BYTE_MODE]  = byte_lanes_low;
				rd_d[`ASF_ST_LOOKAHEAD]  = read_lookahead;
				rd_d[`ASF_ST_WCACHE]     = write_cache;
				rd_d[`ASF_ST_POR_RELOAD] = por_reload_q;
				rd_d[`ASF_ST_FLUSHING]   = cache_flush_req;
				rd_d[`ASF_ST_FATAL]      = fatal_q;
			end
			`ASF_ADDR_MODE: rd_d[23:0] = {long_extra_bytes, 7'h00, dma_mode,
			                              dma_type, iordy_enable, pio_mode};
			`ASF_ADDR_CTRL: rd_d = 32'h0000_0000;
			default: rd_err = 1'b1;
		endcase
	end

	// APB answer: pready rises one cycle into the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (cen) begin
			if (psel && penable && !pready) begin
				pready  <= 1'b1;
				pslverr <= rd_err;
				prdata  <= pwrite ? 32'h0000_0000 : rd_d;
			end else begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

endmodule : asf_decoder

`default_nettype wire

//--- testbench/asf_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none

module asf_chk (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       cmd_done,
	input wire logic       cmd_abort,
	input wire logic       byte_lanes_low,
	input wire logic       iocs16_enable,
	input wire logic [2:0] pio_mode,
	input wire logic [1:0] dma_type,
	input wire logic [7:0] long_extra_bytes,
	input wire logic       read_lookahead,
	input wire logic       cache_flush_req,
	input wire logic       flush_done_pin,
	input wire logic       nv_smart_wr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	pready_time_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready late or early");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	lane_sel_a: assert property (byte_lanes_low |-> !iocs16_enable)
		else $error("wide select in byte mode");
	pio_range_a: assert property (pio_mode <= 3'h4)
		else $error("pio mode out of range");
	dma_code_a: assert property (dma_type != 2'h3)
		else $error("reserved dma type");
	long_bytes_a: assert property (long_extra_bytes == 8'h04)
		else $error("long byte count wrong");
	abort_done_a: assert property (cmd_abort |-> cmd_done)
		else $error("abort without completion");
	abort_keep_a: assert property (cmd_abort |-> $stable(pio_mode) && $stable(read_lookahead))
		else $error("aborted command changed setup");
	cfg_change_a: assert property ($changed(pio_mode) |-> cmd_done || $past(pready))
		else $error("mode changed outside a command");
	flush_wait_a: assert property (cache_flush_req && !flush_done_pin |=> !cmd_done)
		else $error("completion before flush");

	cover property (cmd_abort);
	cover property (cache_flush_req ##1 flush_done_pin);
	cover property (nv_smart_wr);
endmodule : asf_chk

bind asf_decoder asf_chk chk_u (.*);

`default_nettype wire

//--- testbench/asf_backend.sv
`timescale 1ns/1ps
`default_nettype none

module asf_backend #(
	parameter int DLY = 5
) (
	input  wire logic pclk,
	input  wire logic nv_smart_wr,
	input  wire logic nv_smart_data,
	input  wire logic cache_flush_req,
	output logic      nv_smart_pin,
	output logic      flush_done_pin
);
	logic nv_q = 1'h0;
	int   cnt  = 0;

	assign nv_smart_pin = nv_q;
	assign flush_done_pin = cnt >= DLY;

	// The stored state outlives any reset of the decoder.
	always_ff @(posedge pclk)
		if (nv_smart_wr)
			nv_q <= nv_smart_data;

	always_ff @(posedge pclk)
		cnt <= cache_flush_req ? cnt + 1 : 0;
endmodule : asf_backend

`default_nettype wire

//--- testbench/asf_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none

module asf_decoder_tb;
	logic        pclk = 0, presetn = 0, cen = 1, psel = 0, penable = 0, pwrite = 0;
	logic        fatal_error_pin = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	wire logic [31:0] prdata;
	wire logic   pready, pslverr, nv_smart_wr, nv_smart_data, cache_flush_req, cmd_done;
	wire logic   iocs16_enable, byte_lanes_low, iordy_enable, read_lookahead, write_cache;
	wire logic   cmd_abort, flush_done_pin, nv_smart_pin;
	wire logic [2:0] pio_mode, dma_mode;
	wire logic [1:0] dma_type;
	wire logic [7:0] long_extra_bytes;
	int          checks = 0, error_cnt = 0, cyc = 0;

	asf_decoder dut_u (.*);
	asf_backend #(.DLY(12)) be_u (.pclk(pclk), .nv_smart_wr(nv_smart_wr),
		.nv_smart_data(nv_smart_data), .cache_flush_req(cache_flush_req),
		.nv_smart_pin(nv_smart_pin), .flush_done_pin(flush_done_pin));

	initial forever #2 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 8000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		#1;
	endtask : apb

	task automatic wr(input logic [7:0] a, d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, {24'h0, d}, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0, r, e);
		chk("prdata", x, r);
		chk("pslverr", {31'h0, a > 8'h28}, {31'h0, e});
	endtask : rd

	task automatic cmd(input logic [7:0] op, f, c, input logic ab);
		wr(8'h04, f);
		wr(8'h08, c);
		wr(8'h1c, op);
		do @(posedge pclk); while (cmd_done !== 1'h1);
		chk("abort", {31'h0, ab}, {31'h0, cmd_abort});
		#1;
	endtask : cmd

	task automatic sig;
		wr(8'h10, 8'h4f);
		wr(8'h14, 8'hc2);
	endtask : sig

	task automatic t_reset;
		rd(8'h24, 32'h0004_0008);
		rd(8'h20, 32'h80);
		rd(8'h40, 32'h0);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_feat;
		logic [7:0] nop [4] = '{8'h69, 8'h96, 8'h9a, 8'h97};
		cmd(8'hef, 8'h01, 8'h00, 1'h0);
		chk("lanes", 32'h2, {30'h0, byte_lanes_low, iocs16_enable});
		cmd(8'hef, 8'h81, 8'h00, 1'h0);
		chk("lanes", 32'h1, {30'h0, byte_lanes_low, iocs16_enable});
		cmd(8'hef, 8'haa, 8'h00, 1'h0);
		chk("ahead", 32'h1, {31'h0, read_lookahead});
		cmd(8'hef, 8'h55, 8'h00, 1'h0);
		chk("ahead", 32'h0, {31'h0, read_lookahead});
		cmd(8'hef, 8'h02, 8'h00, 1'h0);
		chk("cache", 32'h1, {31'h0, write_cache});
		cmd(8'hef, 8'h82, 8'h00, 1'h0);
		chk("cache", 32'h0, {31'h0, write_cache});
		cmd(8'hef, 8'hbb, 8'h00, 1'h0);
		chk("long", 32'h4, {24'h0, long_extra_bytes});
		foreach (nop[i]) begin
			cmd(8'hef, nop[i], 8'h00, 1'h0);
			rd(8'h24, 32'h0004_0008);
		end
		cmd(8'hef, 8'h00, 8'h00, 1'h1);
		cmd(8'h12, 8'h01, 8'h00, 1'h1);
		chk("lanes", 32'h1, {30'h0, byte_lanes_low, iocs16_enable});
		$display("t_feat done");
	endtask : t_feat

	task automatic t_mode;
		logic [7:0] arg [9] = '{8'h01, 8'h00, 8'h0c, 8'h0d, 8'h10, 8'h22, 8'h23, 8'h44, 8'h45};
		logic [8:0] x [9] = '{9'h000, 9'h000, 9'h080, 9'h180, 9'h180, 9'h08a, 9'h18a,
			9'h094, 9'h194};
		for (int i = 0; i < 9; i++) begin
			cmd(8'hef, 8'h03, arg[i], x[i][8]);
			chk("mode", {24'h0, x[i][7:0]}, {24'h0, pio_mode, dma_type, dma_mode});
			if (i < 2)
				chk("iordy", {31'h0, i == 1}, {31'h0, iordy_enable});
		end
		$display("t_mode done");
	endtask : t_mode

	task automatic t_smart;
		sig();
		cmd(8'hb0, 8'hda, 8'h00, 1'h1);
		cmd(8'hb0, 8'hd9, 8'h00, 1'h1);
		cmd(8'hb0, 8'hd8, 8'h00, 1'h0);
		chk("nv", 32'h1, {31'h0, be_u.nv_q});
		cmd(8'hb0, 8'hd8, 8'h00, 1'h0);
		rd(8'h20, 32'h84);
		cmd(8'hb0, 8'hd2, 8'hf1, 1'h0);
		rd(8'h20, 32'h8c);
		cmd(8'hb0, 8'hd2, 8'h00, 1'h0);
		rd(8'h20, 32'h84);
		cmd(8'hb0, 8'hda, 8'h00, 1'h0);
		rd(8'h10, 32'h4f);
		rd(8'h14, 32'hc2);
		@(posedge pclk) fatal_error_pin <= 1'h1;
		cmd(8'hb0, 8'hda, 8'h00, 1'h0);
		rd(8'h10, 32'hf4);
		rd(8'h14, 32'h2c);
		sig();
		cmd(8'hb0, 8'hd9, 8'h00, 1'h0);
		chk("nv", 32'h0, {31'h0, be_u.nv_q});
		cmd(8'hb0, 8'hd9, 8'h00, 1'h1);
		cmd(8'hb0, 8'hd8, 8'h00, 1'h0);
		cmd(8'hb0, 8'hda, 8'h00, 1'h0);
		rd(8'h10, 32'hf4);
		wr(8'h14, 8'hc3);
		cmd(8'hb0, 8'hd8, 8'h00, 1'h1);
		$display("t_smart done");
	endtask : t_smart

	task automatic t_srst;
		cmd(8'hef, 8'h66, 8'h00, 1'h0);
		cmd(8'hef, 8'haa, 8'h00, 1'h0);
		wr(8'h28, 8'h01);
		chk("ahead", 32'h1, {31'h0, read_lookahead});
		cmd(8'hef, 8'hcc, 8'h00, 1'h0);
		cmd(8'hef, 8'h01, 8'h00, 1'h0);
		wr(8'h28, 8'h01);
		chk("ahead", 32'h0, {31'h0, read_lookahead});
		chk("lanes", 32'h1, {30'h0, byte_lanes_low, iocs16_enable});
		chk("pio", 32'h0, {29'h0, pio_mode});
		@(posedge pclk) presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		repeat (4) @(posedge pclk);
		rd(8'h20, 32'h284);
		$display("t_srst done");
	endtask : t_srst

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		repeat (4) @(posedge pclk);
		t_reset();
		t_feat();
		t_mode();
		t_smart();
		t_srst();
		wrap_up();
	end
endmodule : asf_decoder_tb

`default_nettype wire
